/* File: cpuif_id_reset_dma_regs.sv */
// Purpose: Identity, scratch, soft reset and transfer setup registers
// Assumes: Asynchronous processor strobes, synchronised here; write commits on strobe release
// Notes: Address, data and strobes must stay stable over the two synchroniser cycles
//
// Contract
// - Read-only identity: revision high, part low
// - Scratch word reads back last write, resets zero
// - Bit 1 resets controller registers only
// - Bit 0 resets controller and interface registers
// - Setup: count, burst size, enable, direction
// - Count is bytes; bursts depend bus width
// - Burst field: single, four, eight, sixteen
// - Direction 0 writes memory; enable starts
`timescale 1ns/1ps
`include "cpuif_regs.svh"
module cpuif_id_reset_dma_regs #(
    parameter logic [15:0] HW_REVISION = 16'h00A5, // Arbitrary value
    parameter logic [15:0] PART_CODE = 16'h5A5A // Arbitrary value
) (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic [15:0] cpu_addr_i,
    input wire logic cpu_cs_n_i,
    input wire logic cpu_rd_n_i,
    input wire logic cpu_wr_n_i,
    input wire logic [31:0] cpu_data_i,
    input wire logic bus_width_32_i,
    output logic [31:0] cpu_data_o,
    output logic cpu_data_oe_n_o,
    output logic hc_regs_reset_o,
    output logic all_regs_reset_o,
    output logic [23:0] byte_count_o,
    output logic [1:0] beat_group_size_o,
    output logic [4:0] beats_per_burst_o,
    output logic [23:0] burst_count_o,
    output logic dma_enable_o,
    output logic dma_read_o,
    output logic dma_start_o,
    output logic dma_stop_o
);
    cpuif_srst_if srst ();

    // Pin synchronisers; first stage read only by second
    logic [2:0] strobe_meta_reg;
    logic [2:0] strobe_reg;
    logic [15:0] addr_meta_reg;
    logic [15:0] addr_reg;
    logic [31:0] data_meta_reg;
    logic [31:0] data_reg;
    logic wr_act_d_reg;
    logic [15:0] wr_addr_reg;
    logic [31:0] wr_data_reg;
    logic [31:0] scratch_reg;
    logic [31:0] setup_reg;
    logic [31:0] rd_mux;

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            strobe_meta_reg <= 3'h7;
            strobe_reg <= 3'h7;
            addr_meta_reg <= 16'h0000;
            addr_reg <= 16'h0000;
            data_meta_reg <= `CPUIF_ZERO32;
            data_reg <= `CPUIF_ZERO32;
        end else begin
            strobe_meta_reg <= {cpu_cs_n_i, cpu_rd_n_i, cpu_wr_n_i};
            strobe_reg <= strobe_meta_reg;
            addr_meta_reg <= cpu_addr_i;
            addr_reg <= addr_meta_reg;
            data_meta_reg <= cpu_data_i;
            data_reg <= data_meta_reg;
        end
    end

    wire logic rd_act = ~strobe_reg[2] & ~strobe_reg[1];
    wire logic wr_act = ~strobe_reg[2] & ~strobe_reg[0];
    wire logic commit = wr_act_d_reg & ~wr_act;
    wire logic sel_scratch = (wr_addr_reg == `CPUIF_OFS_SCRATCH);
    wire logic sel_srst = (wr_addr_reg == `CPUIF_OFS_SRST);
    wire logic sel_setup = (wr_addr_reg == `CPUIF_OFS_SETUP);
    wire logic all_clear = srst.all_active;
    wire logic idle = ~srst.busy_all & ~srst.busy_hc;

    // Requests only while idle, so a running sequence is not restarted
    assign srst.req_all = commit & sel_srst & idle & wr_data_reg[`CPUIF_SRST_ALL_BIT];
    assign srst.req_hc = commit & sel_srst & idle & wr_data_reg[`CPUIF_SRST_HC_BIT];

    cpuif_srst_seq u_srst_seq (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .srst(srst),
        .hc_rst_o(hc_regs_reset_o),
        .all_rst_o(all_regs_reset_o)
    );

    function automatic logic [4:0] beats_of(input logic [1:0] code);
        logic [4:0] beats;
        beats = `CPUIF_BEATS_1;
        unique case (code)
            `CPUIF_BURST_SINGLE: beats = `CPUIF_BEATS_1;
            `CPUIF_BURST_4: beats = `CPUIF_BEATS_4;
            `CPUIF_BURST_8: beats = `CPUIF_BEATS_8;
            `CPUIF_BURST_16: beats = `CPUIF_BEATS_16;
        endcase
        return beats;
    endfunction

    // Bursts needed for a byte count, rounded up; a partial burst still runs
    function automatic logic [23:0] bursts_of(input logic [23:0] bytes, input logic wide,
                                              input logic [1:0] code);
        logic [2:0] shift;
        logic [24:0] mask;
        logic [24:0] sum;
        shift = 3'(wide ? 1 : 0) + 3'h1;
        unique case (code)
            `CPUIF_BURST_SINGLE: shift = shift + 3'h0;
            `CPUIF_BURST_4: shift = shift + 3'h2;
            `CPUIF_BURST_8: shift = shift + 3'h3;
            `CPUIF_BURST_16: shift = shift + 3'h4;
        endcase
        mask = (25'h000_0001 << shift) - 25'h000_0001;
        sum = {1'b0, bytes} + mask;
        return 24'(sum >> shift);
    endfunction

    wire logic [1:0] burst_field = setup_reg[`CPUIF_SETUP_BURST_HI:`CPUIF_SETUP_BURST_LO];
    wire logic [23:0] count_field = setup_reg[`CPUIF_SETUP_CNT_HI:`CPUIF_SETUP_CNT_LO];
    // Identity ignores writes; soft reset reserved bits read zero
    assign rd_mux = (addr_reg == `CPUIF_OFS_IDENT) ? {HW_REVISION, PART_CODE} :
                    (addr_reg == `CPUIF_OFS_SCRATCH) ? scratch_reg :
                    (addr_reg == `CPUIF_OFS_SRST) ? {30'h0, srst.busy_hc,
                                                     srst.busy_all} :
                    (addr_reg == `CPUIF_OFS_SETUP) ? setup_reg : `CPUIF_ZERO32;

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_act_d_reg <= 1'b0;
            wr_addr_reg <= 16'h0000;
            wr_data_reg <= `CPUIF_ZERO32;
        end else begin
            wr_act_d_reg <= wr_act;
            if (wr_act) begin
                wr_addr_reg <= addr_reg;
                wr_data_reg <= data_reg;
            end
        end
    end

    // Software keeps reserved bits zero; stored as written
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            scratch_reg <= `CPUIF_ZERO32;
            setup_reg <= `CPUIF_ZERO32;
        end else if (all_clear) begin
            scratch_reg <= `CPUIF_ZERO32;
            setup_reg <= `CPUIF_ZERO32;
        end else if (commit) begin
            if (sel_scratch) begin
                scratch_reg <= wr_data_reg;
            end
            if (sel_setup) begin
                setup_reg <= wr_data_reg;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cpu_data_o <= `CPUIF_ZERO32;
            cpu_data_oe_n_o <= 1'b1;
            byte_count_o <= `CPUIF_ZERO24;
            beat_group_size_o <= `CPUIF_BURST_SINGLE;
            beats_per_burst_o <= `CPUIF_BEATS_1;
            burst_count_o <= `CPUIF_ZERO24;
            dma_enable_o <= 1'b0;
            dma_read_o <= 1'b0;
            dma_start_o <= 1'b0;
            dma_stop_o <= 1'b0;
        end else begin
            cpu_data_o <= rd_mux;
            cpu_data_oe_n_o <= ~rd_act;
            byte_count_o <= count_field;
            beat_group_size_o <= burst_field;
            beats_per_burst_o <= beats_of(burst_field);
            burst_count_o <= bursts_of(count_field, bus_width_32_i, burst_field);
            dma_enable_o <= setup_reg[`CPUIF_SETUP_EN_BIT];
            dma_read_o <= setup_reg[`CPUIF_SETUP_DIR_BIT];
            dma_start_o <= setup_reg[`CPUIF_SETUP_EN_BIT] & ~dma_enable_o;
            dma_stop_o <= ~setup_reg[`CPUIF_SETUP_EN_BIT] & dma_enable_o;
        end
    end

    a_ident_read_value: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (rd_act && addr_reg == `CPUIF_OFS_IDENT) |=> (cpu_data_o == {HW_REVISION, PART_CODE}))
        else $error("identity read wrong");
    a_scratch_write_hold: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (commit && sel_scratch && !all_clear) |=> (scratch_reg == $past(wr_data_reg)))
        else $error("scratch not stored");
    a_all_reset_clears: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        srst.req_all |=> ##1 (all_regs_reset_o && hc_regs_reset_o) ##1 (scratch_reg == 32'h0))
        else $error("full reset failed");
    a_hc_pulse_length: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        $rose(hc_regs_reset_o) |-> hc_regs_reset_o[*8] ##1 !hc_regs_reset_o)
        else $error("controller reset pulse length");
    a_hc_spares_bank: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (srst.req_hc && !srst.req_all) |-> ##1 !all_regs_reset_o [*8])
        else $error("controller reset touched bank");
    a_srst_bits_selfclear: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (srst.req_all || srst.req_hc) |-> ##[9:12] (!srst.busy_all && !srst.busy_hc))
        else $error("reset bits did not clear");
    a_burst_decode_map: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (burst_field == `CPUIF_BURST_8) |=> (beats_per_burst_o == 5'h08))
        else $error("burst decode wrong");
    a_enable_start_pulse: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        $rose(setup_reg[`CPUIF_SETUP_EN_BIT]) |=> (dma_start_o ##1 !dma_start_o))
        else $error("start pulse missing");
    a_setup_count_load: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (commit && sel_setup && !all_clear) |=> ##1 (byte_count_o == $past(wr_data_reg[31:8], 2)))
        else $error("count not loaded");
endmodule

/* File: cpuif_regs.svh */
// Purpose: Offsets, field positions, reset values and timing for the CPU interface bank
// Assumes: Byte addresses on the processor bus, 32-bit registers
// Notes: Definitions only
`ifndef CPUIF_REGS_SVH
`define CPUIF_REGS_SVH

`define CPUIF_ADDR_W 16
`define CPUIF_OFS_IDENT 16'h0304
`define CPUIF_OFS_SCRATCH 16'h0308
`define CPUIF_OFS_SRST 16'h030C
`define CPUIF_OFS_SETUP 16'h0330

`define CPUIF_ZERO32 32'h0000_0000
`define CPUIF_ZERO24 24'h00_0000
`define CPUIF_SRST_ALL_BIT 0
`define CPUIF_SRST_HC_BIT 1
`define CPUIF_SETUP_DIR_BIT 0
`define CPUIF_SETUP_EN_BIT 1
`define CPUIF_SETUP_BURST_LO 2
`define CPUIF_SETUP_BURST_HI 3
`define CPUIF_SETUP_CNT_LO 8
`define CPUIF_SETUP_CNT_HI 31

`define CPUIF_BURST_SINGLE 2'h0
`define CPUIF_BURST_4 2'h1
`define CPUIF_BURST_8 2'h2
`define CPUIF_BURST_16 2'h3
`define CPUIF_BEATS_1 5'h01
`define CPUIF_BEATS_4 5'h04
`define CPUIF_BEATS_8 5'h08
`define CPUIF_BEATS_16 5'h10

// Soft reset pulse length
`define CPUIF_CLK_PERIOD_NS 10
`define CPUIF_SRST_PULSE_NS 80
`define CPUIF_SRST_CYCLES ((`CPUIF_SRST_PULSE_NS + `CPUIF_CLK_PERIOD_NS - 1) / `CPUIF_CLK_PERIOD_NS)

`endif

/* File: cpuif_pkg.sv */
// Purpose: Shared types of the CPU interface bank
// Assumes: Nothing imported by users
// Notes: Gray codes along idle, hold, done
package cpuif_pkg;
    typedef enum logic [1:0] {
        CPUIF_SR_IDLE = 2'h0,
        CPUIF_SR_HOLD = 2'h1,
        CPUIF_SR_DONE = 2'h3
    } cpuif_srst_state_type;
endpackage

/* File: cpuif_srst_if.sv */
// Purpose: Request and status lines between register bank and reset sequencer
// Assumes: Single clock domain
// Notes: Requests are one-cycle pulses
`timescale 1ns/1ps
interface cpuif_srst_if;
    logic req_all;
    logic req_hc;
    logic busy_all;
    logic busy_hc;
    logic all_active;
    modport bank (output req_all, output req_hc, input busy_all, input busy_hc, input all_active);
    modport seq (input req_all, input req_hc, output busy_all, output busy_hc, output all_active);
endinterface

/* File: cpuif_srst_seq.sv */
// Purpose: Soft reset sequencer, holds reset pulses then self-clears
// Assumes: Requests ignored while a sequence runs
// Notes: Full reset wins over controller reset when both asked
`timescale 1ns/1ps
`include "cpuif_regs.svh"
module cpuif_srst_seq #(
    parameter int PULSE_CYCLES = `CPUIF_SRST_CYCLES
) (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    cpuif_srst_if.seq srst,
    output logic hc_rst_o,
    output logic all_rst_o
);
    cpuif_pkg::cpuif_srst_state_type state_reg, state_next;
    logic [7:0] count_reg;
    logic [7:0] count_next;
    logic kind_all_reg;
    logic kind_hc_reg;
    wire logic start = srst.req_all | srst.req_hc;
    wire logic last = (count_reg == 8'h00);

    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        unique case (state_reg)
            cpuif_pkg::CPUIF_SR_IDLE: begin
                if (start) begin
                    state_next = cpuif_pkg::CPUIF_SR_HOLD;
                    count_next = 8'(PULSE_CYCLES - 1);
                end
            end
            cpuif_pkg::CPUIF_SR_HOLD: begin
                if (last) begin
                    state_next = cpuif_pkg::CPUIF_SR_DONE;
                end else begin
                    count_next = count_reg - 8'h01;
                end
            end
            cpuif_pkg::CPUIF_SR_DONE: begin
                state_next = cpuif_pkg::CPUIF_SR_IDLE;
            end
            default: begin
                state_next = cpuif_pkg::CPUIF_SR_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_reg <= cpuif_pkg::CPUIF_SR_IDLE;
            count_reg <= 8'h00;
            kind_all_reg <= 1'b0;
            kind_hc_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
            if (state_reg == cpuif_pkg::CPUIF_SR_IDLE && start) begin
                kind_all_reg <= srst.req_all;
                kind_hc_reg <= srst.req_hc & ~srst.req_all;
            end else if (state_reg == cpuif_pkg::CPUIF_SR_DONE) begin
                kind_all_reg <= 1'b0;
                kind_hc_reg <= 1'b0;
            end
        end
    end

    // Full reset also resets the controller registers
    wire logic hold = (state_next == cpuif_pkg::CPUIF_SR_HOLD);
    wire logic all_next = hold & (state_reg == cpuif_pkg::CPUIF_SR_IDLE ? srst.req_all
                                                                        : kind_all_reg);
    wire logic hc_next = hold;

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hc_rst_o <= 1'b0;
            all_rst_o <= 1'b0;
        end else begin
            hc_rst_o <= hc_next;
            all_rst_o <= all_next;
        end
    end

    assign srst.busy_all = kind_all_reg;
    assign srst.busy_hc = kind_hc_reg;
    assign srst.all_active = all_rst_o;
endmodule

/* File: cpuif_host_model.sv */
// Purpose: Processor model on the asynchronous strobe bus of the register bank
// Assumes: Strobes held 4 cycles, address and data held 4 cycles past release
// Notes: Released lines show the inverse of their last value
`timescale 1ns/1ps
module cpuif_host_model (
    input wire logic ref_clk_i,
    input wire logic [31:0] cpu_data_i,
    input wire logic cpu_data_oe_n_i,
    output logic [15:0] cpu_addr_o,
    output logic cpu_cs_n_o,
    output logic cpu_rd_n_o,
    output logic cpu_wr_n_o,
    output logic [31:0] cpu_data_o
);
    initial begin
        cpu_addr_o = 16'h0000;
        cpu_cs_n_o = 1'b1;
        cpu_rd_n_o = 1'b1;
        cpu_wr_n_o = 1'b1;
        cpu_data_o = 32'h0000_0000;
    end

    // Hold past release covers the two synchroniser stages
    task automatic bus_write(input logic [15:0] addr, input logic [31:0] data);
        @(posedge ref_clk_i);
        cpu_addr_o <= addr;
        cpu_data_o <= data;
        cpu_cs_n_o <= 1'b0;
        cpu_wr_n_o <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        cpu_cs_n_o <= 1'b1;
        cpu_wr_n_o <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        cpu_addr_o <= ~addr;
        cpu_data_o <= ~data;
        repeat (3) @(posedge ref_clk_i);
    endtask

    // Timeout leaves the data unknown so the caller sees a mismatch
    task automatic bus_read(input logic [15:0] addr, output logic [31:0] data);
        int n;
        data = 32'hXXXX_XXXX;
        n = 0;
        @(posedge ref_clk_i);
        cpu_addr_o <= addr;
        cpu_cs_n_o <= 1'b0;
        cpu_rd_n_o <= 1'b0;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (cpu_data_oe_n_i !== 1'b0 && n < 10);
        if (cpu_data_oe_n_i === 1'b0) begin
            data = cpu_data_i;
        end
        cpu_cs_n_o <= 1'b1;
        cpu_rd_n_o <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        cpu_addr_o <= ~addr;
        repeat (3) @(posedge ref_clk_i);
    endtask
endmodule

/* File: cpu_if_id_reset_dma_regs_tb.sv */
// Purpose: Self-checking bench of the identity, scratch, soft reset and setup bank
// Assumes: Host model drives the strobe bus, bench drives bus width
// Notes: Reset pulse lengths counted by monitors on the clock
`timescale 1ns/1ps
`include "cpuif_regs.svh"
module cpu_if_id_reset_dma_regs_tb;
    localparam logic [15:0] REV = 16'h0042; // Arbitrary value
    localparam logic [15:0] PART = 16'h00C3; // Arbitrary value
    logic ref_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic bus_width_32_i = 1'b0;
    logic [15:0] addr;
    logic cs_n, rd_n, wr_n;
    logic [31:0] wdata, rdata_pin, rd, word;
    logic oe_n, hc_rst, all_rst, dma_en, dma_rd, dma_start, dma_stop;
    logic [23:0] byte_cnt, burst_cnt;
    logic [1:0] grp;
    logic [4:0] beats;
    logic [23:0] counts [4] = '{24'h000001, 24'hFFFFFF, 24'h000041, 24'h000040};
    logic [31:0] srst_vals [3] = '{32'h0000_0002, 32'h0000_0001, 32'h0000_0003};
    int error_cnt = 0;
    int n_checks = 0;
    int start_cnt = 0, stop_cnt = 0, hc_hi = 0, all_hi = 0;
    int s0, p0;
    logic full;

    always #5 ref_clk_i = ~ref_clk_i;

    cpuif_host_model i_host (.ref_clk_i(ref_clk_i), .cpu_data_i(rdata_pin),
        .cpu_data_oe_n_i(oe_n), .cpu_addr_o(addr), .cpu_cs_n_o(cs_n), .cpu_rd_n_o(rd_n),
        .cpu_wr_n_o(wr_n), .cpu_data_o(wdata));

    cpuif_id_reset_dma_regs #(.HW_REVISION(REV), .PART_CODE(PART)) i_dut (
        .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .cpu_addr_i(addr),
        .cpu_cs_n_i(cs_n), .cpu_rd_n_i(rd_n), .cpu_wr_n_i(wr_n), .cpu_data_i(wdata),
        .bus_width_32_i(bus_width_32_i), .cpu_data_o(rdata_pin), .cpu_data_oe_n_o(oe_n),
        .hc_regs_reset_o(hc_rst), .all_regs_reset_o(all_rst), .byte_count_o(byte_cnt),
        .beat_group_size_o(grp), .beats_per_burst_o(beats), .burst_count_o(burst_cnt),
        .dma_enable_o(dma_en), .dma_read_o(dma_rd), .dma_start_o(dma_start),
        .dma_stop_o(dma_stop));

    always @(posedge ref_clk_i) begin
        if (dma_start === 1'b1) start_cnt++;
        if (dma_stop === 1'b1) stop_cnt++;
        if (hc_rst === 1'b1) hc_hi++;
        if (all_rst === 1'b1) all_hi++;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic logic [23:0] exp_bursts(input logic [23:0] cnt, input logic [1:0] code,
                                               input logic wide);
        int unit;
        unit = (wide ? 4 : 2) * ((code == 2'h0) ? 1 : (2 << code));
        return 24'((int'(cnt) + unit - 1) / unit);
    endfunction

    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Whole run is near 600 cycles, limit leaves wide margin
    initial begin
        #300000;
        error_cnt++;
        $display("[ERR] watchdog expected end seen hang");
        finish_test();
    end

    initial begin
        repeat (20) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        check("oe_n idle", {31'h0, oe_n}, 32'h0000_0001);
        check("beats reset", {27'h0, beats}, 32'h0000_0001);
        i_host.bus_read(`CPUIF_OFS_IDENT, rd);
        check("identity", rd, {REV, PART});
        i_host.bus_read(`CPUIF_OFS_SCRATCH, rd);
        check("scratch reset", rd, 32'h0000_0000);
        i_host.bus_read(`CPUIF_OFS_SETUP, rd);
        check("setup reset", rd, 32'h0000_0000);
        i_host.bus_read(`CPUIF_OFS_SRST, rd);
        check("srst reset", rd, 32'h0000_0000);
        i_host.bus_read(16'h0310, rd);
        check("unmapped", rd, 32'h0000_0000);
        i_host.bus_write(`CPUIF_OFS_IDENT, 32'hFFFF_FFFF);
        i_host.bus_read(`CPUIF_OFS_IDENT, rd);
        check("identity write", rd, {REV, PART});
        i_host.bus_write(16'h0310, 32'hFFFF_FFFF);
        i_host.bus_read(`CPUIF_OFS_SCRATCH, rd);
        check("unmapped write", rd, 32'h0000_0000);
        i_host.bus_read(16'h0310, rd);
        check("unmapped after write", rd, 32'h0000_0000);
        foreach (srst_vals[k]) begin
            i_host.bus_write(`CPUIF_OFS_SCRATCH, {srst_vals[k][7:0], 24'hA55A5A} ^ 32'hFF00_0000);
            i_host.bus_read(`CPUIF_OFS_SCRATCH, rd);
            check("scratch", rd, {srst_vals[k][7:0], 24'hA55A5A} ^ 32'hFF00_0000);
        end
        for (int i = 0; i < 4; i++) begin
            @(posedge ref_clk_i);
            bus_width_32_i <= i[0] ^ i[1];
            word = {counts[i], 4'h0, i[1:0], ~i[0], i[1]};
            s0 = start_cnt;
            p0 = stop_cnt;
            i_host.bus_write(`CPUIF_OFS_SETUP, word);
            repeat (2) @(posedge ref_clk_i);
            check("byte count", {8'h0, byte_cnt}, {8'h0, counts[i]});
            check("group", {30'h0, grp}, {30'h0, i[1:0]});
            check("beats", {27'h0, beats}, (i == 0) ? 32'h1 : (32'h2 << i));
            check("bursts", {8'h0, burst_cnt},
                  {8'h0, exp_bursts(counts[i], i[1:0], i[0] ^ i[1])});
            check("enable", {31'h0, dma_en}, {31'h0, ~i[0]});
            check("direction", {31'h0, dma_rd}, {31'h0, i[1]});
            check("start", start_cnt - s0, i[0] ? 0 : 1);
            check("stop", stop_cnt - p0, i[0] ? 1 : 0);
            i_host.bus_read(`CPUIF_OFS_SETUP, rd);
            check("setup read", rd, word);
        end
        foreach (srst_vals[k]) begin
            full = srst_vals[k][0];
            i_host.bus_write(`CPUIF_OFS_SCRATCH, 32'h1234_ABCD);
            i_host.bus_write(`CPUIF_OFS_SETUP, 32'h0001_0006);
            hc_hi = 0;
            all_hi = 0;
            i_host.bus_write(`CPUIF_OFS_SRST, srst_vals[k]);
            repeat (20) @(posedge ref_clk_i);
            check("hc pulse", hc_hi, 8);
            check("all pulse", all_hi, full ? 8 : 0);
            check("enable kept", {31'h0, dma_en}, {31'h0, ~full});
            i_host.bus_read(`CPUIF_OFS_SCRATCH, rd);
            check("scratch after", rd, full ? 32'h0 : 32'h1234_ABCD);
            i_host.bus_read(`CPUIF_OFS_SETUP, rd);
            check("setup after", rd, full ? 32'h0 : 32'h0001_0006);
            i_host.bus_read(`CPUIF_OFS_SRST, rd);
            check("srst clear", rd, 32'h0000_0000);
        end
        finish_test();
    end
endmodule
